// ---- hdl/rftr_defines.vh ----
/*
 constants for the rf front-end trim and override register group.
 assumes inclusion by bare name from the design files.
*/
`ifndef RFTR_DEFINES_VH
`define RFTR_DEFINES_VH

// ----------------------------------------
// register word offsets (index), byte address is four times the index
// ----------------------------------------
`define RFTR_IDX_OUTPUT_POWER    8'h1c
`define RFTR_IDX_ANTENNA_MATCH   8'h1d
`define RFTR_IDX_IQ_PHASE        8'h1e
`define RFTR_IDX_IQ_GAIN         8'h1f
`define RFTR_IDX_BLOCK_SLEEP     8'h20
`define RFTR_IDX_SYNTH_FORCED    8'h21
`define RFTR_IDX_PLL_FORCE       8'h22
`define RFTR_IDX_OSC_CAL         8'h23
`define RFTR_IDX_BASE            8'h1c
`define RFTR_NUM_REGS            8

// ----------------------------------------
// reset values
// ----------------------------------------
`define RFTR_RST_OUTPUT_POWER    8'h0f
`define RFTR_RST_ANTENNA_MATCH   8'h00
`define RFTR_RST_IQ_PHASE        8'h00
`define RFTR_RST_IQ_GAIN         8'h00
`define RFTR_RST_BLOCK_SLEEP     8'h00
`define RFTR_RST_SYNTH_FORCED    8'h4d
`define RFTR_RST_PLL_FORCE       8'h10
`define RFTR_RST_OSC_CAL         8'h06

// ----------------------------------------
// field positions
// ----------------------------------------
`define RFTR_NIB_HI              7:4
`define RFTR_NIB_LO              3:0
`define RFTR_BIT_AMP             7
`define RFTR_BIT_OSC             6
`define RFTR_BIT_DIVBUF          5
`define RFTR_BIT_PUMP            4
`define RFTR_BIT_FRONTEND        3
`define RFTR_BIT_VGA             2
`define RFTR_BIT_IMGFILT         1
`define RFTR_BIT_ADC             0
`define RFTR_BIT_LOOP_OPEN       7
`define RFTR_BIT_PUMP_FORCE      6
`define RFTR_BIT_TANK_FORCE      5
`define RFTR_FLD_TANK            4:0
`define RFTR_BIT_MANUAL_CAL      7
`define RFTR_BIT_CUR_FORCE       6
`define RFTR_FLD_OSC_CUR         5:0

// ----------------------------------------
// sleep policy code that lets the block sleep overrides act
// ----------------------------------------
`define RFTR_SLEEP_POLICY_OVR    2'h2

`endif

// ---- hdl/rftr_reg_cell.v ----
/*
 one 8-bit read/write register with a reset value.
 assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rftr_reg_cell #(
	parameter [7:0] RESET_VALUE = 8'h00
) (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire       load,
	input  wire [7:0] load_data,
	output reg  [7:0] value
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			value <= RESET_VALUE;
		end else if (load) begin
			value <= load_data;
		end
	end

endmodule

`default_nettype wire

// ---- hdl/rftr_trim_override_regs.v ----
/*
 rf front-end trim and override register group with avalon-mm slave.
 assumes a word-addressed avalon-mm master on sys_clk; the sleep policy field,
 calibrated values and the calibration comparator come from elsewhere in the chip.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rftr_defines.vh"

module rftr_trim_override_regs (
	input  wire        sys_clk,
	input  wire        rst_n,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	output wire [1:0]  avs_response,
	input  wire [1:0]  sleep_policy_select,
	input  wire [3:0]  cal_dac_value,
	input  wire [3:0]  pump_current_cal,
	input  wire [4:0]  tank_array_cal,
	input  wire [5:0]  osc_current_cal,
	input  wire        manual_cal_comparator,
	output reg  [3:0]  high_array_level,
	output reg  [3:0]  low_array_level,
	output reg  [3:0]  rx_match_code,
	output reg  [3:0]  tx_match_code,
	output reg  [7:0]  iq_phase_correction,
	output reg  [7:0]  iq_gain_correction,
	output reg         amp_sleep,
	output reg         oscillator_sleep,
	output reg         divider_buffer_sleep,
	output reg         pump_sleep,
	output reg         frontend_sleep,
	output reg         variable_gain_sleep,
	output reg         image_rejector_sleep,
	output reg         converter_sleep,
	output reg         pll_loop_open,
	output reg  [3:0]  cal_dac_drive,
	output reg  [3:0]  pump_current,
	output reg  [4:0]  tank_array,
	output reg  [5:0]  osc_current,
	output reg         manual_osc_cal_enable,
	output reg         manual_cal_strobe,
	output reg         manual_cal_sample,
	output reg         manual_cal_result
);

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	localparam [63:0] RESET_VALUES = {`RFTR_RST_OSC_CAL, `RFTR_RST_PLL_FORCE, `RFTR_RST_SYNTH_FORCED,
		`RFTR_RST_BLOCK_SLEEP, `RFTR_RST_IQ_GAIN, `RFTR_RST_IQ_PHASE,
		`RFTR_RST_ANTENNA_MATCH, `RFTR_RST_OUTPUT_POWER};

	wire [7:0]  rel_index;
	wire        hit;
	wire [2:0]  sel;
	wire [63:0] reg_flat;
	reg  [31:0] readdata;
	reg  [1:0]  response;
	reg         answered;
	reg  [1:0]  cmp_sync;
	reg         strobe_prev;

	assign rel_index = avs_address - `RFTR_IDX_BASE;
	assign hit       = (avs_address >= `RFTR_IDX_OUTPUT_POWER) && (avs_address <= `RFTR_IDX_OSC_CAL);
	assign sel       = rel_index[2:0];

	genvar gi;
	generate
		for (gi = 0; gi < `RFTR_NUM_REGS; gi = gi + 1) begin : g_reg
			rftr_reg_cell #(
				.RESET_VALUE (RESET_VALUES[gi*8 +: 8])
			) u_cell (
				.sys_clk   (sys_clk),
				.rst_n     (rst_n),
				.load      (avs_write && answered && hit && (sel == gi) && avs_byteenable[0]),
				.load_data (avs_writedata[7:0]),
				.value     (reg_flat[gi*8 +: 8])
			);
		end
	endgenerate

	wire [7:0] r_power  = reg_flat[7:0];
	wire [7:0] r_match  = reg_flat[15:8];
	wire [7:0] r_phase  = reg_flat[23:16];
	wire [7:0] r_gain   = reg_flat[31:24];
	wire [7:0] r_sleep  = reg_flat[39:32];
	wire [7:0] r_synth  = reg_flat[47:40];
	wire [7:0] r_pll    = reg_flat[55:48];
	wire [7:0] r_osccal = reg_flat[63:56];

	// ----------------------------------------
	// avalon-mm slave: one wait cycle, answer on the second edge
	// ----------------------------------------
	assign avs_waitrequest = (avs_read || avs_write) && !answered;
	assign avs_readdata    = readdata;
	assign avs_response    = response;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			answered <= 1'b0;
			readdata <= 32'h00000000;
			response <= 2'h0;
		end else if ((avs_read || avs_write) && !answered) begin
			answered <= 1'b1;
			response <= hit ? 2'h0 : 2'h2;
			if (avs_read && hit) begin
				readdata <= {24'h000000, reg_flat[sel*8 +: 8]};
			end else begin
				readdata <= 32'h00000000;
			end
		end else begin
			answered <= 1'b0;
		end
	end

	// ----------------------------------------
	// comparator synchroniser
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_sync <= 2'h0;
		end else begin
			cmp_sync <= {cmp_sync[0], manual_cal_comparator};
		end
	end

	// ----------------------------------------
	// control outputs
	// ----------------------------------------
	wire policy_ovr = (sleep_policy_select == `RFTR_SLEEP_POLICY_OVR);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_array_level      <= 4'h0;
			low_array_level       <= 4'h0;
			rx_match_code         <= 4'h0;
			tx_match_code         <= 4'h0;
			iq_phase_correction   <= 8'h00;
			iq_gain_correction    <= 8'h00;
			amp_sleep             <= 1'b0;
			oscillator_sleep      <= 1'b0;
			divider_buffer_sleep  <= 1'b0;
			pump_sleep            <= 1'b0;
			frontend_sleep        <= 1'b0;
			variable_gain_sleep   <= 1'b0;
			image_rejector_sleep  <= 1'b0;
			converter_sleep       <= 1'b0;
			pll_loop_open         <= 1'b0;
			cal_dac_drive         <= 4'h0;
			pump_current          <= 4'h0;
			tank_array            <= 5'h00;
			osc_current           <= 6'h00;
			manual_osc_cal_enable <= 1'b0;
			manual_cal_strobe     <= 1'b0;
			strobe_prev           <= 1'b0;
			manual_cal_sample     <= 1'b0;
			manual_cal_result     <= 1'b0;
		end else begin
			high_array_level      <= r_power[`RFTR_NIB_HI];
			low_array_level       <= r_power[`RFTR_NIB_LO];
			rx_match_code         <= r_match[`RFTR_NIB_HI];
			tx_match_code         <= r_match[`RFTR_NIB_LO];
			iq_phase_correction   <= r_phase;
			iq_gain_correction    <= r_gain;
			amp_sleep             <= policy_ovr && r_sleep[`RFTR_BIT_AMP];
			oscillator_sleep      <= policy_ovr && r_sleep[`RFTR_BIT_OSC];
			divider_buffer_sleep  <= policy_ovr && r_sleep[`RFTR_BIT_DIVBUF];
			pump_sleep            <= policy_ovr && r_sleep[`RFTR_BIT_PUMP];
			frontend_sleep        <= policy_ovr && r_sleep[`RFTR_BIT_FRONTEND];
			variable_gain_sleep   <= policy_ovr && r_sleep[`RFTR_BIT_VGA];
			image_rejector_sleep  <= policy_ovr && r_sleep[`RFTR_BIT_IMGFILT];
			converter_sleep       <= policy_ovr && r_sleep[`RFTR_BIT_ADC];
			pll_loop_open         <= r_pll[`RFTR_BIT_LOOP_OPEN];
			cal_dac_drive         <= r_pll[`RFTR_BIT_LOOP_OPEN] ? r_synth[`RFTR_NIB_HI] : cal_dac_value;
			pump_current          <= r_pll[`RFTR_BIT_PUMP_FORCE] ? r_synth[`RFTR_NIB_LO] : pump_current_cal;
			tank_array            <= r_pll[`RFTR_BIT_TANK_FORCE] ? r_pll[`RFTR_FLD_TANK] : tank_array_cal;
			osc_current           <= r_osccal[`RFTR_BIT_CUR_FORCE] ? r_osccal[`RFTR_FLD_OSC_CUR] : osc_current_cal;
			manual_osc_cal_enable <= r_osccal[`RFTR_BIT_MANUAL_CAL];
			manual_cal_strobe     <= r_osccal[`RFTR_BIT_MANUAL_CAL] && r_osccal[`RFTR_BIT_CUR_FORCE];
			strobe_prev           <= r_osccal[`RFTR_BIT_CUR_FORCE];
			manual_cal_sample     <= r_osccal[`RFTR_BIT_MANUAL_CAL] && strobe_prev
				&& !r_osccal[`RFTR_BIT_CUR_FORCE];
			if (r_osccal[`RFTR_BIT_MANUAL_CAL] && strobe_prev && !r_osccal[`RFTR_BIT_CUR_FORCE]) begin
				manual_cal_result <= cmp_sync[1];
			end
		end
	end

endmodule

`default_nettype wire

// ---- sim/rftr_regs_props.sv ----
/* assertions for the trim and override register group.
   assumes binding to rftr_trim_override_regs on its own ports. */
`timescale 1ns/1ps
`default_nettype none
module rftr_regs_props (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response,
	input wire logic [1:0]  sleep_policy_select,
	input wire logic [3:0]  cal_dac_value,
	input wire logic [3:0]  high_array_level,
	input wire logic [7:0]  iq_phase_correction,
	input wire logic        amp_sleep,
	input wire logic        oscillator_sleep,
	input wire logic        converter_sleep,
	input wire logic        pll_loop_open,
	input wire logic [3:0]  cal_dac_drive,
	input wire logic        manual_cal_sample
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// write accepted into a register
	sequence taken(logic [7:0] a);
		avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == a;
	endsequence
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	a_unmapped_err: assert property (avs_read && !avs_waitrequest && !(avs_address inside {[8'h1c:8'h23]})
		|-> avs_response == 2'h2) else $error("unmapped read without error response");
	a_high_level: assert property (taken(8'h1c) |-> ##2 high_array_level == $past(avs_writedata[7:4], 2))
		else $error("high array level not from write");
	a_phase_trim: assert property (taken(8'h1e) |-> ##2 iq_phase_correction == $past(avs_writedata[7:0], 2))
		else $error("phase trim not from write");
	a_loop_open: assert property (taken(8'h22) |-> ##2 pll_loop_open == $past(avs_writedata[7], 2))
		else $error("loop open bit not from write");
	a_amp_gated: assert property (amp_sleep |-> $past(sleep_policy_select) == 2'h2)
		else $error("amplifier sleep outside policy two");
	a_osc_gated: assert property (oscillator_sleep |-> $past(sleep_policy_select) == 2'h2)
		else $error("oscillator sleep outside policy two");
	a_adc_gated: assert property (converter_sleep |-> $past(sleep_policy_select) == 2'h2)
		else $error("converter sleep outside policy two");
	a_dac_closed: assert property ($past(rst_n) && !pll_loop_open |-> cal_dac_drive == $past(cal_dac_value))
		else $error("dac not calibrated value with loop closed");
	a_sample_pulse: assert property (manual_cal_sample |=> !manual_cal_sample)
		else $error("sample pulse longer than one cycle");
endmodule
bind rftr_trim_override_regs rftr_regs_props i_rftr_regs_props (.*);
`default_nettype wire

// ---- sim/rftr_host_model.sv ----
/* host model: avalon-mm master issuing one transfer at a time.
   assumes the bench top rftr_trim_override_regs_test for hang reporting. */
`timescale 1ns/1ps
`default_nettype none
module rftr_host_model (
	input wire logic        sys_clk,
	input wire logic        avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	input wire logic [1:0]  avs_response,
	output var logic [7:0]  avs_address = 8'h00,
	output var logic        avs_read = 1'b0,
	output var logic        avs_write = 1'b0,
	output var logic [31:0] avs_writedata = 32'h0,
	output var logic [3:0]  avs_byteenable = 4'h0
);
	// hold the request until waitrequest is seen low at a rising edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be,
		output logic [7:0] q, output logic [1:0] r);
		int n;
		logic w;
		n = 0;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge sys_clk);
			w = avs_waitrequest;
			q = avs_readdata[7:0];
			r = avs_response;
			n++;
		end while (w !== 1'b0 && n < 20);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
		if (w !== 1'b0) begin
			$display("BAD t=%0t waitrequest=%h exp=%h", $time, w, 1'b0);
			rftr_trim_override_regs_test.failures++;
			rftr_trim_override_regs_test.complete_run();
		end
	endtask
endmodule
`default_nettype wire

// ---- sim/rftr_trim_override_regs_test.sv ----
/* self-checking bench for the trim and override register group.
   assumes rftr_host_model as bus master and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module rftr_trim_override_regs_test;
	logic sys_clk = 1'b0, rst_n = 1'b0, comp = 1'b0;
	logic [1:0] pol = 2'h0, r;
	logic [3:0] cdac = 4'h3;
	logic [7:0] q, a_s, rd_s, wr_s;
	logic [31:0] rdat;
	logic [1:0] resp;
	wire logic wreq, rdq, wrq;
	wire logic [31:0] wd;
	wire logic [3:0] be, hi, lo, rxm, txm, dac, pmp;
	wire logic [7:0] ph, gn, slp;
	wire logic [4:0] tank;
	wire logic [5:0] ocur;
	wire logic lop, men, mstr, mres, msmp;
	int failures = 0, checked = 0;
	int pulses = 0;
	logic [7:0] dflt [8] = '{8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h4d, 8'h10, 8'h06};
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (msmp === 1'b1) pulses++;
	rftr_host_model i_rftr_host_model (.sys_clk(sys_clk), .avs_waitrequest(wreq), .avs_readdata(rdat),
		.avs_response(resp), .avs_address(a_s), .avs_read(rdq), .avs_write(wrq), .avs_writedata(wd),
		.avs_byteenable(be));
	rftr_trim_override_regs i_rftr_trim_override_regs (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(a_s),
		.avs_read(rdq), .avs_write(wrq), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .avs_response(resp), .sleep_policy_select(pol), .cal_dac_value(cdac),
		.pump_current_cal(4'h7), .tank_array_cal(5'h0a), .osc_current_cal(6'h2b), .manual_cal_comparator(comp),
		.high_array_level(hi), .low_array_level(lo), .rx_match_code(rxm), .tx_match_code(txm),
		.iq_phase_correction(ph), .iq_gain_correction(gn), .amp_sleep(slp[7]), .oscillator_sleep(slp[6]),
		.divider_buffer_sleep(slp[5]), .pump_sleep(slp[4]), .frontend_sleep(slp[3]),
		.variable_gain_sleep(slp[2]), .image_rejector_sleep(slp[1]), .converter_sleep(slp[0]),
		.pll_loop_open(lop), .cal_dac_drive(dac), .pump_current(pmp), .tank_array(tank), .osc_current(ocur),
		.manual_osc_cal_enable(men), .manual_cal_strobe(mstr), .manual_cal_sample(msmp), .manual_cal_result(mres));
	// ----------------------------------------
	// checks and bus helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_rftr_host_model.xfer(1'b1, a, d, 4'hf, q, r);
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [9:0] e);
		i_rftr_host_model.xfer(1'b0, a, 8'h00, 4'hf, q, r);
		chk({r, q}, e);
	endtask
	task automatic complete_run;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 8; i++) rd(8'(8'h1c + i), {2'h0, dflt[i]});
		chk({hi, lo, dac, pmp, tank, ocur}, {8'h0f, 4'h3, 4'h7, 5'h0a, 6'h2b});
		wr(8'h1c, 8'hf0);
		chk({hi, lo}, 8'hf0);
		wr(8'h1d, 8'h5a);
		chk({rxm, txm}, 8'h5a);
		wr(8'h1e, 8'h80);
		wr(8'h1f, 8'h7f);
		chk({ph, gn}, 16'h807f);
		pol <= 2'h1;
		wr(8'h20, 8'hff);
		chk(slp, 8'h00);
		pol <= 2'h2;
		repeat (2) @(posedge sys_clk);
		chk(slp, 8'hff);
		wr(8'h20, 8'h60);
		chk(slp, 8'h60);
		wr(8'h21, 8'h9c);
		wr(8'h22, 8'he3);
		chk({lop, dac, pmp, tank}, {1'b1, 4'h9, 4'hc, 5'h03});
		wr(8'h22, 8'h00);
		chk({lop, dac, pmp, tank}, {1'b0, 4'h3, 4'h7, 5'h0a});
		cdac <= 4'h6;
		repeat (2) @(posedge sys_clk);
		chk(dac, 4'h6);
		wr(8'h23, 8'h55);
		chk({men, ocur}, {1'b0, 6'h15});
		comp <= 1'b1;
		wr(8'h23, 8'hc0);
		chk({men, mstr}, 2'b11);
		wr(8'h23, 8'h80);
		chk(mres, 1'b1);
		for (int i = 0; i < 8; i++) wr(8'(8'h1c + i), 8'(8'h3c + 8'h11 * i));
		for (int i = 0; i < 8; i++) rd(8'(8'h1c + i), {2'h0, 8'(8'h3c + 8'h11 * i)});
		i_rftr_host_model.xfer(1'b1, 8'h1c, 8'h00, 4'he, q, r);
		rd(8'h1c, 10'h03c);
		i_rftr_host_model.xfer(1'b1, 8'h05, 8'hff, 4'hf, q, r);
		rd(8'h05, 10'h200);
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 8; i++) rd(8'(8'h1c + i), {2'h0, dflt[i]});
		chk({hi, lo, slp, dac}, 20'h0f006);
		chk(pulses, 1);
		complete_run();
	end
endmodule
`default_nettype wire
